// [core/data_move_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module data_move_decode #(
  parameter logic [11:0] ACC_ADDR = 12'hFE8,
  parameter logic [11:0] PC_LOW_ADDR = 12'hFF9,
  parameter logic [11:0] STACK_TOP_UPPER_ADDR = 12'hFFF,
  parameter logic [11:0] STACK_TOP_HIGH_ADDR = 12'hFFE,
  parameter logic [11:0] STACK_TOP_LOW_ADDR = 12'hFFD,
  parameter logic [3:0] ACCESS_HI_BANK = 4'hF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  // Mode and index base
  input wire logic ext_set_en,
  input wire logic [data_move_pkg::ADDR_W-1:0] index_base,
  // Data memory
  output data_move_pkg::mem_req_t mem_req,
  input wire logic [7:0] rd_data,
  // Core registers
  output logic [7:0] acc,
  output logic [7:0] bank_select_reg,
  output logic move_busy
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] phase;
    data_move_pkg::fsm_t fsm;
    logic src_is_acc;
    logic [7:0] data;
    logic [7:0] acc;
    logic [7:0] bank;
    logic pend_acc;
    logic pend_bank;
    logic pend_mem;
    logic [11:0] pend_addr;
    logic [7:0] pend_val;
    data_move_pkg::mem_req_t req;
  } state_t;

  localparam state_t STATE_RESET = '{
    phase: data_move_pkg::PH_Q1,
    fsm: data_move_pkg::ST_DECODE,
    src_is_acc: 1'b0,
    data: 8'h00,
    acc: data_move_pkg::ACC_RESET,
    bank: data_move_pkg::BANK_RESET,
    pend_acc: 1'b0,
    pend_bank: 1'b0,
    pend_mem: 1'b0,
    pend_addr: 12'h000,
    pend_val: 8'h00,
    req: '0
  };

  state_t state_reg;
  state_t state_next;
  logic take;
  logic [11:0] store_addr;
  logic [11:0] word_addr;
  logic dst_locked;

  // Word taken only at the decode phase
  assign instr_ready = (state_reg.phase == data_move_pkg::PH_Q1);
  assign take = instr_valid && instr_ready;
  assign word_addr = instr_word[11:0];

  assign dst_locked = (word_addr == PC_LOW_ADDR) || (word_addr == STACK_TOP_UPPER_ADDR) ||
                      (word_addr == STACK_TOP_HIGH_ADDR) || (word_addr == STACK_TOP_LOW_ADDR);

  // Store address from bank, access or index
  file_addr_resolve #(
    .ACCESS_HI_BANK(ACCESS_HI_BANK)
  ) u_resolve (
    .file_addr(instr_word[7:0]),
    .use_bank(instr_word[8]),
    .bank_sel(state_reg.bank),
    .ext_set_en(ext_set_en),
    .index_base(index_base),
    .full_addr(store_addr)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.phase = state_reg.phase + 2'h1;
    state_next.req.rd_en = 1'b0;
    state_next.req.wr_en = 1'b0;
    // Decode of a new word
    if (take) begin
      state_next.pend_acc = 1'b0;
      state_next.pend_bank = 1'b0;
      state_next.pend_mem = 1'b0;
      state_next.pend_val = instr_word[7:0];
      if (state_reg.fsm == data_move_pkg::ST_MOVE_DST) begin
        state_next.fsm = data_move_pkg::ST_DECODE;
        if (instr_word[15:12] == data_move_pkg::PREFIX_MOVE_DST) begin
          state_next.pend_val = state_reg.data;
          state_next.pend_addr = word_addr;
          state_next.pend_acc = (word_addr == ACC_ADDR);
          state_next.pend_mem = (word_addr != ACC_ADDR) && !dst_locked;
        end
      end else if (instr_word[15:12] == data_move_pkg::PREFIX_MOVE_SRC) begin
        // full 12-bit source read in Q2
        state_next.fsm = data_move_pkg::ST_MOVE_DST;
        state_next.src_is_acc = (word_addr == ACC_ADDR);
        state_next.req.rd_en = (word_addr != ACC_ADDR);
        state_next.req.rd_addr = word_addr;
      end else if (instr_word[15:8] == data_move_pkg::OPC_LOAD_BANK) begin
        state_next.pend_bank = 1'b1;
      end else if (instr_word[15:8] == data_move_pkg::OPC_LOAD_ACC) begin
        state_next.pend_acc = 1'b1;
      end else if (instr_word[15:9] == data_move_pkg::OPC_STORE_ACC) begin
        state_next.pend_val = state_reg.acc;
        state_next.pend_addr = store_addr;
        state_next.pend_acc = (store_addr == ACC_ADDR);
        state_next.pend_mem = (store_addr != ACC_ADDR);
      end
    end
    // source latched in Q2 of the first cycle only; a stalled move keeps it
    if (state_reg.phase == data_move_pkg::PH_Q2 && (state_reg.req.rd_en || state_reg.src_is_acc)) begin
      state_next.data = state_reg.src_is_acc ? state_reg.acc : rd_data;
      state_next.src_is_acc = 1'b0;
    end
    if (state_reg.phase == data_move_pkg::PH_Q3 && state_reg.pend_mem) begin
      state_next.req.wr_en = 1'b1;
      state_next.req.wr_addr = state_reg.pend_addr;
      state_next.req.wr_data = state_reg.pend_val;
      state_next.pend_mem = 1'b0;
    end
    // Register writes at the end of Q4
    if (state_reg.phase == data_move_pkg::PH_Q4) begin
      if (state_reg.pend_acc) begin
        state_next.acc = state_reg.pend_val;
      end
      if (state_reg.pend_bank) begin
        state_next.bank = state_reg.pend_val & data_move_pkg::BANK_KEEP_MASK;
      end
      state_next.pend_acc = 1'b0;
      state_next.pend_bank = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs from state
  assign mem_req = state_reg.req;
  assign acc = state_reg.acc;
  assign bank_select_reg = state_reg.bank;
  assign move_busy = (state_reg.fsm == data_move_pkg::ST_MOVE_DST);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_src_read_q2: assert property (
    mem_req.rd_en |-> state_reg.phase == data_move_pkg::PH_Q2 && move_busy)
    else $error("source read outside Q2 of a move");

  a_no_dummy_read: assert property (
    $past(move_busy) && state_reg.phase == data_move_pkg::PH_Q2 |-> !mem_req.rd_en)
    else $error("dummy read in second move cycle");

  a_write_in_q4: assert property (
    mem_req.wr_en |-> state_reg.phase == data_move_pkg::PH_Q4)
    else $error("memory write outside Q4");

  a_src_full_addr: assert property (
    take && !move_busy && instr_word[15:12] == data_move_pkg::PREFIX_MOVE_SRC && word_addr != ACC_ADDR
    |=> mem_req.rd_en && mem_req.rd_addr == $past(word_addr))
    else $error("source address not read in full");

  a_move_copy: assert property (
    take && move_busy && instr_word[15:12] == data_move_pkg::PREFIX_MOVE_DST && word_addr != ACC_ADDR
    && !dst_locked |-> ##3 mem_req.wr_en && mem_req.wr_addr == $past(word_addr, 3)
    && mem_req.wr_data == state_reg.data)
    else $error("move did not copy source to destination");

  a_acc_as_dest: assert property (
    take && move_busy && instr_word[15:12] == data_move_pkg::PREFIX_MOVE_DST && word_addr == ACC_ADDR
    |-> ##3 !mem_req.wr_en ##1 acc == state_reg.data)
    else $error("accumulator destination not written");

  a_bank_load: assert property (
    take && !move_busy && instr_word[15:8] == data_move_pkg::OPC_LOAD_BANK
    |-> ##4 bank_select_reg == {4'h0, $past(instr_word[3:0], 4)})
    else $error("bank literal not loaded");

  a_bank_high_zero: assert property (
    bank_select_reg[7:4] == 4'h0)
    else $error("bank select upper nibble not zero");

  a_acc_load: assert property (
    take && !move_busy && instr_word[15:8] == data_move_pkg::OPC_LOAD_ACC
    |-> ##3 acc == $past(acc, 3) ##1 acc == $past(instr_word[7:0], 4))
    else $error("accumulator literal not loaded at Q4");

  a_store_write: assert property (
    take && !move_busy && instr_word[15:9] == data_move_pkg::OPC_STORE_ACC && store_addr != ACC_ADDR
    |-> ##3 mem_req.wr_en && mem_req.wr_data == $past(acc, 3))
    else $error("accumulator store not written");

  a_store_indexed: assert property (
    take && !move_busy && instr_word[15:9] == data_move_pkg::OPC_STORE_ACC && !instr_word[8] && ext_set_en
    && instr_word[7:0] <= data_move_pkg::ACCESS_LIMIT && store_addr != ACC_ADDR
    |-> ##3 mem_req.wr_addr == $past(index_base + {4'h0, instr_word[7:0]}, 3))
    else $error("indexed store address wrong");

endmodule
`default_nettype wire

// [core/data_move_pkg.sv]
`default_nettype none
package data_move_pkg;

  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [3:0] PREFIX_MOVE_SRC = 4'hC;
  localparam logic [3:0] PREFIX_MOVE_DST = 4'hF;
  localparam logic [7:0] OPC_LOAD_BANK = 8'h01;
  localparam logic [7:0] OPC_LOAD_ACC = 8'h0E;
  localparam logic [6:0] OPC_STORE_ACC = 7'h37;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [7:0] BANK_KEEP_MASK = 8'h0F;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam int MOVE_CYCLES = 2;

  // ----------------------------------------
  // Phases of one instruction cycle
  // ----------------------------------------
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic {
    ST_DECODE = 1'b0,
    ST_MOVE_DST = 1'b1
  } fsm_t;

  // Data memory request carrier
  typedef struct packed {
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_data;
  } mem_req_t;

endpackage
`default_nettype wire

// [core/file_addr_resolve.sv]
`timescale 1ns/1ps
`default_nettype none
module file_addr_resolve #(
  parameter logic [3:0] ACCESS_HI_BANK = 4'hF
) (
  // Operand
  input wire logic [7:0] file_addr,
  input wire logic use_bank,
  // Context
  input wire logic [7:0] bank_sel,
  input wire logic ext_set_en,
  input wire logic [data_move_pkg::ADDR_W-1:0] index_base,
  // Result
  output logic [data_move_pkg::ADDR_W-1:0] full_addr
);

  // Bank, indexed or access bank address
  always_comb begin
    if (use_bank) begin
      full_addr = {bank_sel[3:0], file_addr};
    end else if (file_addr <= data_move_pkg::ACCESS_LIMIT) begin
      if (ext_set_en) begin
        full_addr = index_base + {4'h0, file_addr};
      end else begin
        full_addr = {4'h0, file_addr};
      end
    end else begin
      full_addr = {ACCESS_HI_BANK, file_addr};
    end
  end

endmodule
`default_nettype wire

// [tb/data_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  // Clock
  input wire logic clk,
  // Request and answer
  input wire data_move_pkg::mem_req_t req,
  output logic [7:0] rd_data
);
  // ----------------------------------------
  // Data space
  // ----------------------------------------
  logic [7:0] mem [4096];
  logic [7:0] last_rd;

  // Known fill pattern
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'hA5;
    end
    last_rd = 8'h00;
  end

  // Combinational read; junk outside a strobe
  assign rd_data = req.rd_en ? mem[req.rd_addr] : ~last_rd;

  // Writes land at the edge
  always @(posedge clk) begin
    if (req.rd_en) begin
      last_rd <= mem[req.rd_addr];
    end
    if (req.wr_en) begin
      mem[req.wr_addr] <= req.wr_data;
    end
  end
endmodule
`default_nettype wire

// [tb/data_move_instruction_decode_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module data_move_instruction_decode_bench;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  logic clk, rst_b, instr_valid, instr_ready, ext_set_en, move_busy, q4_busy, q1_ready, q2_ready;
  logic [15:0] instr_word;
  logic [11:0] index_base;
  logic [7:0] rd_data, acc, bank_select_reg, q1_acc, q1_bank;
  data_move_pkg::mem_req_t mem_req, q2, q4;
  int n_fail, cmp_count;

  data_move_decode dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .ext_set_en(ext_set_en), .index_base(index_base), .mem_req(mem_req),
    .rd_data(rd_data), .acc(acc), .bank_select_reg(bank_select_reg), .move_busy(move_busy));
  data_mem_model mdl (.clk(clk), .req(mem_req), .rd_data(rd_data));

  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction

  // One word per instruction cycle, sampling Q1, Q2 and Q4
  task automatic issue(input logic [15:0] w);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(negedge clk);
    q1_acc = acc;
    q1_bank = bank_select_reg;
    q1_ready = instr_ready;
    @(negedge clk);
    q2 = mem_req;
    q2_ready = instr_ready;
    repeat (2) @(negedge clk);
    q4 = mem_req;
    q4_busy = move_busy;
    @(posedge clk);
  endtask

  // Literal loads seen through a banked store
  task automatic t_literals;
    logic [7:0] k [3] = '{8'h5A, 8'hFF, 8'h00};
    for (int i = 0; i < 3; i++) begin
      issue({data_move_pkg::OPC_LOAD_ACC, k[i]});
      issue({data_move_pkg::OPC_LOAD_BANK, k[i]});
      issue({data_move_pkg::OPC_STORE_ACC, 1'b1, 8'h10});
      check(12'(q1_acc), 12'(k[i]));
      check(12'(q1_bank), {8'h00, k[i][3:0]});
      check(q4.wr_addr, {k[i][3:0], 8'h10});
      check(12'(q4.wr_en), 12'h001);
      check(12'(q4.wr_data), 12'(k[i]));
    end
  endtask

  // Access bank against indexed offset; bit 8 turns the extension on
  task automatic t_access;
    logic [8:0] f [4] = '{9'h05F, 9'h060, 9'h15F, 9'h160};
    logic [11:0] exp [4] = '{12'h05F, 12'hF60, 12'h04F, 12'hF60};
    index_base <= 12'hFF0;
    for (int i = 0; i < 4; i++) begin
      ext_set_en <= f[i][8];
      issue({data_move_pkg::OPC_STORE_ACC, 1'b0, f[i][7:0]});
      check(q4.wr_addr, exp[i]);
    end
    ext_set_en <= 1'b0;
  endtask

  // Back-to-back moves over the whole space
  task automatic t_move;
    logic [11:0] s [3] = '{12'h123, 12'h000, 12'hFFC};
    logic [11:0] d [3] = '{12'h456, 12'hFF8, 12'h000};
    // destinations avoid counter and stack bytes
    for (int i = 0; i < 3; i++) begin
      issue({data_move_pkg::PREFIX_MOVE_SRC, s[i]});
      check(12'(q1_ready), 12'h001);
      check(12'(q2_ready), 12'h000);
      check(12'(q2.rd_en), 12'h001);
      check(q2.rd_addr, s[i]);
      check(12'(q4_busy), 12'h001);
      issue({data_move_pkg::PREFIX_MOVE_DST, d[i]});
      check(12'(q2.rd_en), 12'h000);
      check(12'(q4.wr_en), 12'h001);
      check(q4.wr_addr, d[i]);
      check(12'(q4.wr_data), 12'(pat(s[i])));
      check(12'(q4_busy), 12'h000);
    end
  endtask

  // Accumulator as move source and destination
  task automatic t_acc_move;
    issue({data_move_pkg::OPC_LOAD_ACC, 8'h77});
    issue({data_move_pkg::PREFIX_MOVE_SRC, 12'hFE8});
    check(12'(q2.rd_en), 12'h000);
    issue({data_move_pkg::PREFIX_MOVE_DST, 12'h200});
    check(12'(q4.wr_data), 12'h077);
    issue({data_move_pkg::PREFIX_MOVE_SRC, 12'h300});
    issue({data_move_pkg::PREFIX_MOVE_DST, 12'hFE8});
    check(12'(q4.wr_en), 12'h000);
    issue({data_move_pkg::OPC_STORE_ACC, 1'b1, 8'h20});
    check(12'(q1_acc), 12'(pat(12'h300)));
  endtask

  // Reset in mid-move clears the pending move and the registers
  task automatic t_reset;
    issue({data_move_pkg::PREFIX_MOVE_SRC, 12'h123});
    rst_b <= 1'b0;
    instr_valid <= 1'b0;
    @(negedge clk);
    check(12'(move_busy), 12'h000);
    check(12'(instr_ready), 12'h001);
    check(12'(bank_select_reg), 12'h000);
    check(12'(acc), 12'h000);
    @(posedge clk);
    rst_b <= 1'b1;
    issue({data_move_pkg::PREFIX_MOVE_DST, 12'h456});
    check(12'(q4.wr_en), 12'h000);
    issue({data_move_pkg::OPC_LOAD_BANK, 8'h93});
    issue({data_move_pkg::OPC_LOAD_ACC, 8'h3C});
    check(12'(q1_bank), 12'h003);
    issue({data_move_pkg::OPC_STORE_ACC, 1'b0, 8'h80});
    check(12'(q1_acc), 12'h03C);
    check(q4.wr_addr, 12'hF80);
    check(12'(q4.wr_data), 12'h03C);
  endtask

  // Verdict
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    wrap_up;
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    ext_set_en = 1'b0;
    index_base = 12'h000;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_literals;
    t_access;
    t_move;
    t_acc_move;
    t_reset;
    instr_valid <= 1'b0;
    wrap_up;
  end
endmodule
`default_nettype wire
